// file: design/pcid_consts.svh
`ifndef PCID_CONSTS_SVH
`define PCID_CONSTS_SVH
// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define PCID_IDX_LANE2 8'h07
`define PCID_IDX_LANE3 8'h08
`define PCID_IDX_LANE4 8'h09
`define PCID_IDX_LANE8 8'h0D
`define PCID_IDX_WDT 8'h0F
`define PCID_IDX_FILT 8'h11
`define PCID_IDX_COLD 8'h12
`define PCID_IDX_RAMP 8'h13
`define PCID_IDX_A_SPREAD_EN 8'h18
`define PCID_IDX_A_SHAPE 8'h1C
`define PCID_IDX_A_RATIO 8'h20
`define PCID_IDX_A_BEND 8'h24
`define PCID_IDX_B_SPREAD_EN 8'h28
`define PCID_IDX_B_SHAPE 8'h2C
`define PCID_IDX_CTRL 8'h30
`define PCID_IDX_STATUS 8'h31
// ********************************************************************
// Reset values
// ********************************************************************
`define PCID_RST_LANE2 32'h0000_0001
`define PCID_RST_LANE3 32'h0000_0001
`define PCID_RST_LANE4 32'h0000_0000
`define PCID_RST_LANE8 32'h0000_0000
`define PCID_RST_WDT 32'h0000_0000
`define PCID_RST_FILT 32'h0000_0000
`define PCID_RST_COLD 32'h0000_0000
`define PCID_RST_RAMP 32'h0000_00A0
`define PCID_RST_SPREAD_EN 32'h0000_0000
`define PCID_RST_SHAPE 32'h07D9_C12B
`define PCID_RST_RATIO 32'h0000_007D
`define PCID_RST_BEND 32'h7D00_0000
// ********************************************************************
// Writable bit masks (reserved bits read zero)
// ********************************************************************
`define PCID_MSK_BYTE 32'h0000_00FF
`define PCID_MSK_SPREAD_EN 32'h0000_0003
`define PCID_MSK_SHAPE 32'hFFFF_F7FF
`define PCID_MSK_RATIO 32'h01FF_FFFF
`define PCID_MSK_BEND 32'hFFFF_FFFF
// ********************************************************************
// Field positions
// ********************************************************************
`define PCID_SEL_LSB 0
`define PCID_SPREAD_OVR_BIT 0
`define PCID_SPREAD_EN_BIT 1
`define PCID_PERIOD_LSB 0
`define PCID_MODE_LSB 9
`define PCID_STEP_LSB 12
`define PCID_FB_LSB 0
`define PCID_CAM_A_LSB 8
`define PCID_CAM_C_LSB 10
`define PCID_HOLD_OFF_BIT 12
`define PCID_HOLD_ON_BIT 13
`define PCID_REF_LSB 14
`define PCID_VCO_LSB 16
`define PCID_OUT_LSB 18
`define PCID_BEND_FRAC_LSB 0
`define PCID_BEND_INT_LSB 24
`define PCID_CTRL_COMMIT_BIT 0
// ********************************************************************
// Lane select codes
// ********************************************************************
`define PCID_CODE_USB3 2'h0
`define PCID_CODE_PCIE 2'h1
`define PCID_CODE_SATA 2'h2
// ********************************************************************
// Timing
// ********************************************************************
`define PCID_CLK_PERIOD_PS 5000
`define PCID_DEBOUNCE_NS 1000
`define PCID_DEBOUNCE_CYC ((`PCID_DEBOUNCE_NS * 1000 + `PCID_CLK_PERIOD_PS - 1) / `PCID_CLK_PERIOD_PS)
`define PCID_RAMP_TICK_US 32
`endif

// file: design/pcid_pkg.sv
package pcid_pkg;
    // Owner of a shared high-speed lane
    typedef enum logic [1:0] {PCID_OWN_USB3, PCID_OWN_PCIE, PCID_OWN_SATA} pcid_lane_owner_t;

    typedef struct packed {
        pcid_lane_owner_t lane2;
        pcid_lane_owner_t lane3;
        pcid_lane_owner_t lane4;
        pcid_lane_owner_t lane8;
    } pcid_lanes_t;

    // Decoded controls of one PLL
    typedef struct packed {
        logic spread_on;
        logic [1:0] spread_mode;
        logic [8:0] spread_half_period_minus_one;
        logic [10:0] spread_period_refclk;
        logic [19:0] spread_step;
        logic [3:0] vco_output_divider;
        logic pll_enable;
        logic [7:0] feedback_integer_ratio;
        logic [6:0] post_divide_ratio;
        logic [1:0] reference_divide_ratio;
        logic [1:0] camera_clock_select_a;
        logic [1:0] camera_clock_select_c;
        logic [7:0] bend_integer;
        logic [23:0] bend_fraction;
    } pcid_pll_t;

    typedef enum {PCID_RAMP_IDLE, PCID_RAMP_WAIT, PCID_RAMP_DONE} pcid_ramp_state_t;
endpackage

// file: design/pcid_decoder.sv
`timescale 1ns/1ps
`include "pcid_consts.svh"

// Contract
// - Lanes two and three: code 00 routes USB3, 01 PCIe; PCIe default.
// - Lane four: code 00 routes USB3 (default), code 01 routes PCIe.
// - Lane eight: code 00 routes USB3 (default), code 10 routes SATA.
// - Watchdog inhibit zero lets expiry reboot and enables reset break.
// - Filter-off zero keeps reset button debounced; one bypasses debouncing.
// - Non-zero cold-reset byte issues cold reset on commit only when PLL words differ from reset, so PLL changes apply.
// - Ramp timer waits programmed RTC ticks of 32 us on sleep exit.
// - Control word bit 1 enables spreading, bit 0 overrides to apply it.
// - Mode bits 10:9 pick down, up, centre-down or centre-up spread.
// - Bits 8:0 set modulation period of 2*(value+1) reference clocks.
// - Bits 31:12 set fractional modulation step, default 0x7D9C.
// - Bits 17:16 divide VCO by 1, 2, 4 or 8.
// - Bit 13 forces PLL on, bit 12 off; else power state rules.
// - Bits 7:0 hold integer feedback ratio, default 125.
// - Bending word: integer ratio in 31:24, fractional shift in 23:0.
// - Post, reference and camera select fields are stored but unused.
module pcid_decoder
    import pcid_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `PCID_DEBOUNCE_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    input wire logic rtc_tick,
    input wire logic sleep_exit_start,
    input wire logic watchdog_expire,
    input wire logic reset_button_raw,
    input wire logic pll_a_power_on,
    input wire logic pll_b_power_on,
    output pcid_lanes_t lanes,
    output pcid_pll_t pll_a,
    output pcid_pll_t pll_b,
    output logic platform_reboot,
    output logic reset_break_enable,
    output logic reset_button_clean,
    output logic cold_reset_req,
    output logic ramp_done,
    output logic config_latched
);
    localparam int NREG = 14;
    localparam logic [7:0] IDX [NREG] = '{`PCID_IDX_LANE2, `PCID_IDX_LANE3, `PCID_IDX_LANE4,
        `PCID_IDX_LANE8, `PCID_IDX_WDT, `PCID_IDX_FILT, `PCID_IDX_COLD, `PCID_IDX_RAMP,
        `PCID_IDX_A_SPREAD_EN, `PCID_IDX_A_SHAPE, `PCID_IDX_A_RATIO, `PCID_IDX_A_BEND,
        `PCID_IDX_B_SPREAD_EN, `PCID_IDX_B_SHAPE};
    localparam logic [31:0] RST [NREG] = '{`PCID_RST_LANE2, `PCID_RST_LANE3, `PCID_RST_LANE4,
        `PCID_RST_LANE8, `PCID_RST_WDT, `PCID_RST_FILT, `PCID_RST_COLD, `PCID_RST_RAMP,
        `PCID_RST_SPREAD_EN, `PCID_RST_SHAPE, `PCID_RST_RATIO, `PCID_RST_BEND,
        `PCID_RST_SPREAD_EN, `PCID_RST_SHAPE};
    localparam logic [31:0] MSK [NREG] = '{`PCID_MSK_BYTE, `PCID_MSK_BYTE, `PCID_MSK_BYTE,
        `PCID_MSK_BYTE, `PCID_MSK_BYTE, `PCID_MSK_BYTE, `PCID_MSK_BYTE, `PCID_MSK_BYTE,
        `PCID_MSK_SPREAD_EN, `PCID_MSK_SHAPE, `PCID_MSK_RATIO, `PCID_MSK_BEND,
        `PCID_MSK_SPREAD_EN, `PCID_MSK_SHAPE};
    localparam int L2 = 0, L3 = 1, L4 = 2, L8 = 3, WDT = 4, FLT = 5, CLD = 6, RMP = 7;
    localparam int AEN = 8, ASH = 9, ART = 10, ABN = 11, BEN = 12, BSH = 13;

    // A one-cycle window would pass every glitch; the window counter is 16 bits
    if (DEBOUNCE_CYC < 2 || DEBOUNCE_CYC > 65535)
    begin : g_bad_debounce
        $error("DEBOUNCE_CYC out of range");
    end

    // ****************************************************************
    // Avalon-MM slave: one wait state, answer at the second edge
    // ****************************************************************
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    logic [31:0] shadow_q [NREG];
    logic [31:0] shadow_d [NREG];
    logic [31:0] active_q [NREG];
    logic [31:0] active_d [NREG];
    logic latched_q, latched_d;
    logic [NREG-1:0] hit;
    logic [7:0] widx;
    logic req, wr_fire, commit, any_hit, ramp_busy;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_fire = avs_write & ack_q;
    assign widx = avs_address[9:2];
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;
    assign any_hit = |hit;

    // Per-register decode and software write with reserved bits masked
    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_reg
            assign hit[g] = (widx == IDX[g]);
            always_comb
            begin
                shadow_d[g] = shadow_q[g];
                active_d[g] = active_q[g];
                if (wr_fire && hit[g])
                begin
                    shadow_d[g] = avs_writedata & MSK[g];
                end
                if (commit)
                begin
                    active_d[g] = shadow_q[g];
                end
            end
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    shadow_q[g] <= RST[g];
                    active_q[g] <= RST[g];
                end
                else
                begin
                    shadow_q[g] <= shadow_d[g];
                    active_q[g] <= active_d[g];
                end
            end
        end
    endgenerate

    // Only the first commit after reset takes, so the controls never move mid-run
    assign commit = wr_fire && (widx == `PCID_IDX_CTRL) && avs_writedata[`PCID_CTRL_COMMIT_BIT] && !latched_q;

    // Read mux; unmapped addresses read zero with a decode-error response
    always_comb
    begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        resp_d = resp_q;
        latched_d = latched_q | commit;
        if (req && !ack_q)
        begin
            rdata_d = 32'h0000_0000;
            resp_d = 2'h0;
            for (int i = 0; i < NREG; i++)
                rdata_d = hit[i] ? shadow_q[i] : rdata_d;
            if (widx == `PCID_IDX_CTRL)
            begin
                rdata_d = {31'h0000_0000, latched_q};
            end
            else if (widx == `PCID_IDX_STATUS)
            begin
                rdata_d = {29'h0000_0000, ramp_busy, ramp_done, latched_q};
            end
            else if (!any_hit)
            begin
                resp_d = 2'h3;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'h0;
            latched_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            latched_q <= latched_d;
        end
    end
    assign config_latched = latched_q;

    // ****************************************************************
    // Lane owner decode
    // ****************************************************************
    // Unknown codes fall back to the lane's default owner
    function automatic pcid_lane_owner_t dec_lane(input logic [1:0] code, input logic [1:0] alt,
                                                  input pcid_lane_owner_t alt_owner,
                                                  input pcid_lane_owner_t dflt);
        return (code == `PCID_CODE_USB3) ? PCID_OWN_USB3 : ((code == alt) ? alt_owner : dflt);
    endfunction

    assign lanes.lane2 = dec_lane(active_q[L2][1:0], `PCID_CODE_PCIE, PCID_OWN_PCIE, PCID_OWN_PCIE);
    assign lanes.lane3 = dec_lane(active_q[L3][1:0], `PCID_CODE_PCIE, PCID_OWN_PCIE, PCID_OWN_PCIE);
    assign lanes.lane4 = dec_lane(active_q[L4][1:0], `PCID_CODE_PCIE, PCID_OWN_PCIE, PCID_OWN_USB3);
    assign lanes.lane8 = dec_lane(active_q[L8][1:0], `PCID_CODE_SATA, PCID_OWN_SATA, PCID_OWN_USB3);

    // ****************************************************************
    // PLL control decode
    // ****************************************************************
    function automatic pcid_pll_t dec_pll(input logic [31:0] en_w, input logic [31:0] sh_w,
                                          input logic [31:0] rt_w, input logic [31:0] bn_w,
                                          input logic power_on);
        pcid_pll_t p;
        p.spread_on = en_w[`PCID_SPREAD_OVR_BIT] & en_w[`PCID_SPREAD_EN_BIT];
        p.spread_mode = sh_w[`PCID_MODE_LSB +: 2];
        p.spread_half_period_minus_one = sh_w[`PCID_PERIOD_LSB +: 9];
        p.spread_period_refclk = {1'b0, sh_w[`PCID_PERIOD_LSB +: 9], 1'b0} + 11'h002;
        p.spread_step = sh_w[`PCID_STEP_LSB +: 20];
        p.vco_output_divider = 4'h1 << rt_w[`PCID_VCO_LSB +: 2];
        // Force-on beats force-off so a misprogrammed pair never kills the clock
        p.pll_enable = rt_w[`PCID_HOLD_ON_BIT] | (~rt_w[`PCID_HOLD_OFF_BIT] & power_on);
        p.feedback_integer_ratio = rt_w[`PCID_FB_LSB +: 8];
        p.post_divide_ratio = rt_w[`PCID_OUT_LSB +: 7];
        p.reference_divide_ratio = rt_w[`PCID_REF_LSB +: 2];
        p.camera_clock_select_a = rt_w[`PCID_CAM_A_LSB +: 2];
        p.camera_clock_select_c = rt_w[`PCID_CAM_C_LSB +: 2];
        p.bend_integer = bn_w[`PCID_BEND_INT_LSB +: 8];
        p.bend_fraction = bn_w[`PCID_BEND_FRAC_LSB +: 24];
        return p;
    endfunction

    // The second PLL has no ratio or bending words; it runs on their defaults
    assign pll_a = dec_pll(active_q[AEN], active_q[ASH], active_q[ART], active_q[ABN], pll_a_power_on);
    assign pll_b = dec_pll(active_q[BEN], active_q[BSH], `PCID_RST_RATIO, `PCID_RST_BEND, pll_b_power_on);

    // ****************************************************************
    // Watchdog, cold reset and reset button filter
    // ****************************************************************
    logic reboot_q, reboot_d, brk_q, brk_d, cold_q, cold_d, clean_q, clean_d;
    logic [15:0] db_cnt_q, db_cnt_d;
    logic pll_changed;

    assign pll_changed = (shadow_q[AEN] != `PCID_RST_SPREAD_EN) || (shadow_q[ASH] != `PCID_RST_SHAPE) ||
                         (shadow_q[ART] != `PCID_RST_RATIO) || (shadow_q[ABN] != `PCID_RST_BEND) ||
                         (shadow_q[BEN] != `PCID_RST_SPREAD_EN) || (shadow_q[BSH] != `PCID_RST_SHAPE);

    always_comb
    begin
        reboot_d = watchdog_expire && (active_q[WDT][7:0] == 8'h00);
        brk_d = (active_q[WDT][7:0] == 8'h00);
        cold_d = commit && (shadow_q[CLD][7:0] != 8'h00) && pll_changed;
        db_cnt_d = 16'h0000;
        clean_d = clean_q;
        if (active_q[FLT][7:0] != 8'h00)
        begin
            clean_d = reset_button_raw;
        end
        else if (reset_button_raw != clean_q)
        begin
            // Level must hold the whole window before it is believed
            db_cnt_d = db_cnt_q + 16'h0001;
            if (db_cnt_q == 16'(DEBOUNCE_CYC - 1))
            begin
                clean_d = reset_button_raw;
                db_cnt_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reboot_q <= 1'b0;
            brk_q <= 1'b0;
            cold_q <= 1'b0;
            clean_q <= 1'b0;
            db_cnt_q <= 16'h0000;
        end
        else
        begin
            reboot_q <= reboot_d;
            brk_q <= brk_d;
            cold_q <= cold_d;
            clean_q <= clean_d;
            db_cnt_q <= db_cnt_d;
        end
    end
    assign platform_reboot = reboot_q;
    assign reset_break_enable = brk_q;
    assign cold_reset_req = cold_q;
    assign reset_button_clean = clean_q;

    // ****************************************************************
    // Rail ramp timer on synchronised RTC ticks
    // ****************************************************************
    pcid_ramp_state_t st_q, st_d;
    logic [7:0] ticks_q, ticks_d;
    logic sync1_q, sync2_q, sync3_q, tick_en;

    assign tick_en = sync2_q & ~sync3_q;
    assign ramp_busy = (st_q == PCID_RAMP_WAIT);
    assign ramp_done = (st_q == PCID_RAMP_DONE);

    always_comb
    begin
        st_d = st_q;
        ticks_d = ticks_q;
        case (st_q)
            // A restart from done is allowed, so both states share the start path
            PCID_RAMP_IDLE, PCID_RAMP_DONE:
            begin
                if (sleep_exit_start)
                begin
                    ticks_d = 8'h00;
                    st_d = (active_q[RMP][7:0] == 8'h00) ? PCID_RAMP_DONE : PCID_RAMP_WAIT;
                end
            end
            PCID_RAMP_WAIT:
            begin
                if (tick_en)
                begin
                    ticks_d = ticks_q + 8'h01;
                    if (ticks_q + 8'h01 == active_q[RMP][7:0])
                    begin
                        st_d = PCID_RAMP_DONE;
                    end
                end
            end
            default:
            begin
                st_d = PCID_RAMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= PCID_RAMP_IDLE;
            ticks_q <= 8'h00;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ticks_q <= ticks_d;
            sync1_q <= rtc_tick;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_lane2_decode: assert property (active_q[L2][1:0] != `PCID_CODE_USB3 |-> lanes.lane2 == PCID_OWN_PCIE)
        else $error("lane2 not PCIe for non-USB3 code");
    a_lane4_decode: assert property (active_q[L4][1:0] != `PCID_CODE_PCIE |-> lanes.lane4 == PCID_OWN_USB3)
        else $error("lane4 not USB3 for non-PCIe code");
    a_lane8_decode: assert property (lanes.lane8 == PCID_OWN_SATA |-> active_q[L8][1:0] == `PCID_CODE_SATA)
        else $error("lane8 SATA without code 10");
    a_reboot_gate: assert property (watchdog_expire && active_q[WDT][7:0] == 8'h00 |=> platform_reboot)
        else $error("watchdog expiry did not reboot");
    a_reboot_block: assert property (platform_reboot |-> $past(active_q[WDT][7:0]) == 8'h00)
        else $error("reboot while inhibited");
    a_filter_bypass: assert property (active_q[FLT][7:0] != 8'h00 && $stable(active_q[FLT])
                                      |=> reset_button_clean == $past(reset_button_raw))
        else $error("bypassed button not followed");
    a_filter_hold: assert property (active_q[FLT][7:0] == 8'h00 && $stable(active_q[FLT]) && $changed(reset_button_raw)
                                    |=> $stable(reset_button_clean))
        else $error("debounced output moved at once");
    a_cold_reset: assert property (cold_reset_req |-> $past(commit) && $past(shadow_q[CLD][7:0]) != 8'h00)
        else $error("cold reset without enabled commit");
    a_ramp_count: assert property (ramp_busy && tick_en && ticks_q + 8'h01 == active_q[RMP][7:0]
                                   |=> ramp_done)
        else $error("ramp did not finish at programmed count");
    a_ramp_early: assert property ($rose(ramp_done) && $past(ramp_busy)
                                   |-> ticks_q == active_q[RMP][7:0])
        else $error("ramp finished early");
    a_spread_apply: assert property (pll_a.spread_on == (active_q[AEN][1] & active_q[AEN][0]))
        else $error("spread enable not gated by override");
    a_hold_prio: assert property (active_q[ART][`PCID_HOLD_OFF_BIT] && !active_q[ART][`PCID_HOLD_ON_BIT]
                                  |-> !pll_a.pll_enable)
        else $error("forced-off PLL enabled");
    a_latch_once: assert property (latched_q |=> $stable(active_q[ART]) && $stable(active_q[L2]))
        else $error("active controls moved after latch");
    a_bus_answer: assert property (req && !ack_q |=> !avs_waitrequest)
        else $error("bus answer late");

    c_commit: cover property (commit ##1 latched_q);
    c_ramp: cover property (sleep_exit_start ##[1:1000] $rose(ramp_done));
    c_cold: cover property (cold_reset_req);
    c_unmapped: cover property (avs_read && !avs_waitrequest && avs_response == 2'h3);
endmodule

// file: dv/pcid_rtc_model.sv
`timescale 1ns/1ps
// *****
// RTC tick source
// *****
module pcid_rtc_model #(
    parameter int HALF = 10
)(
    input wire logic clk,
    input wire logic run,
    output logic rtc_tick
);
    int cnt = 0;
    // Idle low between wake-ups, so a stale level never looks like a tick
    always @(posedge clk)
    begin
        if (!run)
        begin
            cnt <= 0;
            rtc_tick <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            rtc_tick <= ~rtc_tick;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

// file: dv/tb_pcid_decoder.sv
`timescale 1ns/1ps
module tb_pcid_decoder;
    import pcid_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sleep_exit_start = 1'b0;
    logic watchdog_expire = 1'b0, reset_button_raw = 1'b0, rtc_run = 1'b0;
    logic [9:0] avs_address = 10'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [1:0] avs_response, rsp;
    logic avs_waitrequest, rtc_tick, platform_reboot, reset_break_enable, reset_button_clean;
    logic cold_reset_req, ramp_done, config_latched;
    pcid_lanes_t lanes;
    pcid_pll_t pll_a, pll_b;
    int n_mismatch = 0, n_checks = 0, n_boot = 0, n_cold = 0, n;
    // *****
    // Harness
    // *****
    initial forever #2.5 clk = ~clk;
    pcid_rtc_model #(.HALF(10)) pcid_rtc_model_i (.clk, .run(rtc_run), .rtc_tick);
    // Power request held low on pll_a so only the hold-on bit can enable it
    pcid_decoder #(.DEBOUNCE_CYC(4)) pcid_decoder_i (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_response, .avs_waitrequest, .rtc_tick, .sleep_exit_start,
        .watchdog_expire, .reset_button_raw, .pll_a_power_on(1'b0), .pll_b_power_on(1'b1), .lanes, .pll_a,
        .pll_b, .platform_reboot, .reset_break_enable, .reset_button_clean, .cold_reset_req, .ramp_done,
        .config_latched);
    // Pulses are counted so their exact cycle never races the checks
    always @(posedge clk)
    begin
        if (platform_reboot === 1'b1) n_boot++;
        if (cold_reset_req === 1'b1) n_cold++;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer; held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task pulse_wd;
        @(posedge clk);
        watchdog_expire <= 1'b1;
        @(posedge clk);
        watchdog_expire <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // *****
    // Scenarios
    // *****
    task t_defaults;
        bus(0, 10'h01C, 0); chk(rd, 32'h1);
        bus(0, 10'h024, 0); chk(rd, 32'h0);
        bus(0, 10'h04C, 0); chk(rd, 32'hA0);
        bus(0, 10'h070, 0); chk(rd, 32'h07D9_C12B);
        bus(0, 10'h3FC, 0); chk(rsp, 2'h3);
        chk({lanes.lane2, lanes.lane4, lanes.lane8}, {PCID_OWN_PCIE, PCID_OWN_USB3, PCID_OWN_USB3});
        chk({pll_a.feedback_integer_ratio, pll_a.bend_integer}, 16'h7D7D);
        chk(pll_b.pll_enable, 1'b1);
        chk({pll_a.spread_period_refclk, pll_a.spread_half_period_minus_one}, 20'h4B12B);
        chk({pll_b.spread_on, pll_b.feedback_integer_ratio, pll_b.vco_output_divider}, 13'h07D1);
        chk(config_latched, 1'b0);
        pulse_wd;
        chk(n_boot, 1);
        chk(reset_break_enable, 1'b1);
        reset_button_raw <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk); chk(reset_button_clean, 1'b0);
        repeat (6) @(posedge clk);
        @(negedge clk); chk(reset_button_clean, 1'b1);
    endtask
    task t_program;
        bus(1, 10'h01C, 0); bus(1, 10'h024, 3); bus(1, 10'h034, 2); bus(1, 10'h03C, 1);
        bus(1, 10'h044, 1); bus(1, 10'h048, 1); bus(1, 10'h04C, 2);
        bus(1, 10'h060, 32'hFFFF_FFFF); bus(0, 10'h060, 0); chk(rd, 32'h3);
        bus(1, 10'h070, 32'h07D9_C72B); bus(1, 10'h080, 32'h0107_AE40); bus(1, 10'h090, 32'h7E00_0123);
        chk(lanes.lane2, PCID_OWN_PCIE);
        bus(1, 10'h0C0, 1);
        @(negedge clk);
        chk({lanes.lane2, lanes.lane3, lanes.lane4, lanes.lane8},
            {PCID_OWN_USB3, PCID_OWN_PCIE, PCID_OWN_USB3, PCID_OWN_SATA});
        chk({pll_a.spread_on, pll_a.spread_mode, pll_a.vco_output_divider, pll_a.pll_enable}, 8'hF1);
        chk({pll_a.spread_step, pll_a.feedback_integer_ratio}, 28'h07D9C40);
        chk({pll_a.post_divide_ratio, pll_a.reference_divide_ratio, pll_a.camera_clock_select_c,
            pll_a.camera_clock_select_a}, 13'h106E);
        chk({pll_a.bend_integer, pll_a.bend_fraction}, 32'h7E00_0123);
        chk(config_latched, 1'b1);
        pulse_wd;
        chk(n_cold, 1);
        chk(n_boot, 1);
        chk(reset_break_enable, 1'b0);
        reset_button_raw <= 1'b0;
        @(posedge clk);
        @(negedge clk); chk(reset_button_clean, 1'b0);
    endtask
    task t_ramp;
        @(posedge clk);
        sleep_exit_start <= 1'b1;
        rtc_run <= 1'b1;
        @(posedge clk);
        sleep_exit_start <= 1'b0;
        for (n = 1; n < 80 && ramp_done !== 1'b1; n++) @(negedge clk);
        chk(n >= 30 && n <= 40, 1'b1);
        bus(0, 10'h0C4, 0); chk(rd, 32'h3);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults;
        t_program;
        t_ramp;
        finish_test;
    end
    // Whole run is under two hundred cycles; this cuts a hang short
    initial
    begin
        #20000;
        n_mismatch++;
        finish_test;
    end
endmodule
